// ==== fast_ethernet_pcs_4b5b_codec.v ====
// 100 Mbps coding sublayer: MII nibbles to scrambled MLT-3 code groups
// and back, with delimiter handling, error and collision signalling.
// Assumes the line clock arrives on a pin from the line side and the
// line symbol buses are stable around its rising edge.
`timescale 1ns/1ns
`include "pcs_codec_regs.vh"

// Overview of operation
// - One 5-bit code group per MII nibble
// - Idle code groups while transmit enable low
// - First two nibbles become J/K delimiter
// - Encode remaining nibbles while enable stays high
// - After enable drops send T/R, then idle
// - Nibbles 0 to 7 map per table
// - Nibbles 8 to F map per table
// - J always followed directly by K
// - T always followed directly by R
// - Received J/K becomes two preamble nibbles
// - Received preamble always passed to MAC
// - Scramble before MLT-3, descramble after
// - Invalid received code group within a frame raises receive error
// - Collision flag held while collision lasts
// - J is 11000, K is 10001
// - T is 01101, R is 00111
// - Invalid code group shows nibble 0101
// - Supply both MII clocks at 25 MHz
module fast_ethernet_pcs_4b5b_codec #(
  parameter [10:0] SCR_SEED = `PCS_SCR_SEED  // Transmit scrambler start state
) (
  // System clock and reset
  input  wire       clk_sys_in,
  input  wire       rst_in,
  // Line side
  input  wire       line_clk_in,
  input  wire [9:0] rx_line_in,
  output wire [9:0] tx_line_out,
  // MII transmit
  output wire       tx_clk_out,
  input  wire [3:0] txd_in,
  input  wire       tx_en_in,
  // MII receive
  output wire       rx_clk_out,
  output wire [3:0] rxd_out,
  output wire       rx_dv_out,
  output wire       rx_er_out,
  output wire       crs_out,
  output wire       col_out,
  // Configuration strap
  input  wire       full_duplex_in
);

  // ------------------------
  // State codes, one-hot
  // ------------------------
  localparam [3:0] TX_IDLE = 4'h1;  // Sending idle fill
  localparam [3:0] TX_K    = 4'h2;  // J sent, K owed
  localparam [3:0] TX_DATA = 4'h4;  // Encoding frame nibbles
  localparam [3:0] TX_R    = 4'h8;  // T sent, R owed
  localparam [3:0] RX_IDLE = 4'h1;  // Waiting for J
  localparam [3:0] RX_K    = 4'h2;  // J seen, expecting K
  localparam [3:0] RX_DATA = 4'h4;  // Decoding frame
  localparam [3:0] RX_R    = 4'h8;  // T seen, expecting R

  // ------------------------
  // Input synchronisers
  // ------------------------
  reg       lclk_s1_r;      // Line clock, first stage
  reg       lclk_s2_r;      // Line clock, second stage
  reg       lclk_s3_r;      // Line clock, edge history
  reg [3:0] txd_s1_r;       // Transmit nibble, first stage
  reg [3:0] txd_s2_r;       // Transmit nibble, second stage
  reg       txen_s1_r;      // Transmit enable, first stage
  reg       txen_s2_r;      // Transmit enable, second stage
  reg [9:0] rxl_s1_r;       // Received levels, first stage
  reg [9:0] rxl_s2_r;       // Received levels, second stage
  reg       fdx_s1_r;       // Duplex strap, first stage
  reg       fdx_s2_r;       // Duplex strap, second stage

  // Every pin but clock and reset passes two flops and only the second stage is read, except the line clock, whose third stage also feeds edge detection
  always @(posedge clk_sys_in) begin
    if (rst_in) begin
      lclk_s1_r <= 1'b0;
      lclk_s2_r <= 1'b0;
      lclk_s3_r <= 1'b0;
      txd_s1_r  <= 4'h0;
      txd_s2_r  <= 4'h0;
      txen_s1_r <= 1'b0;
      txen_s2_r <= 1'b0;
      rxl_s1_r  <= 10'h000;
      rxl_s2_r  <= 10'h000;
      fdx_s1_r  <= 1'b0;
      fdx_s2_r  <= 1'b0;
    end else begin
      lclk_s1_r <= line_clk_in;
      lclk_s2_r <= lclk_s1_r;
      lclk_s3_r <= lclk_s2_r;
      txd_s1_r  <= txd_in;
      txd_s2_r  <= txd_s1_r;
      txen_s1_r <= tx_en_in;
      txen_s2_r <= txen_s1_r;
      rxl_s1_r  <= rx_line_in;
      rxl_s2_r  <= rxl_s1_r;
      fdx_s1_r  <= full_duplex_in;
      fdx_s2_r  <= fdx_s1_r;
    end
  end

  // One symbol time per line clock rise
  wire line_rise = lclk_s2_r & ~lclk_s3_r;

  // ------------------------
  // Coding functions
  // ------------------------
  // Nibble to data code group
  function [4:0] enc4;
    input [3:0] n;
    begin
      case (n)
        4'h0:    enc4 = `PCS_CG_D0;
        4'h1:    enc4 = `PCS_CG_D1;
        4'h2:    enc4 = `PCS_CG_D2;
        4'h3:    enc4 = `PCS_CG_D3;
        4'h4:    enc4 = `PCS_CG_D4;
        4'h5:    enc4 = `PCS_CG_D5;
        4'h6:    enc4 = `PCS_CG_D6;
        4'h7:    enc4 = `PCS_CG_D7;
        4'h8:    enc4 = `PCS_CG_D8;
        4'h9:    enc4 = `PCS_CG_D9;
        4'ha:    enc4 = `PCS_CG_DA;
        4'hb:    enc4 = `PCS_CG_DB;
        4'hc:    enc4 = `PCS_CG_DC;
        4'hd:    enc4 = `PCS_CG_DD;
        4'he:    enc4 = `PCS_CG_DE;
        default: enc4 = `PCS_CG_DF;
      endcase
    end
  endfunction

  // Data code group to {valid, nibble}; controls and junk are not valid
  function [4:0] dec5;
    input [4:0] c;
    begin
      case (c)
        `PCS_CG_D0: dec5 = 5'h10;
        `PCS_CG_D1: dec5 = 5'h11;
        `PCS_CG_D2: dec5 = 5'h12;
        `PCS_CG_D3: dec5 = 5'h13;
        `PCS_CG_D4: dec5 = 5'h14;
        `PCS_CG_D5: dec5 = 5'h15;
        `PCS_CG_D6: dec5 = 5'h16;
        `PCS_CG_D7: dec5 = 5'h17;
        `PCS_CG_D8: dec5 = 5'h18;
        `PCS_CG_D9: dec5 = 5'h19;
        `PCS_CG_DA: dec5 = 5'h1a;
        `PCS_CG_DB: dec5 = 5'h1b;
        `PCS_CG_DC: dec5 = 5'h1c;
        `PCS_CG_DD: dec5 = 5'h1d;
        `PCS_CG_DE: dec5 = 5'h1e;
        `PCS_CG_DF: dec5 = 5'h1f;
        default:    dec5 = {1'b0, `PCS_PRE_NIB};
      endcase
    end
  endfunction

  // Additive scrambler, x^11 + x^9 + 1, bit 4 on the line first.
  // Returns {next state, output}; the same call descrambles.
  function [15:0] scr5;
    input [10:0] s;
    input [4:0]  d;
    reg   [10:0] st;
    reg   [4:0]  o;
    reg          k;
    integer      i;
    begin
      st = s;
      o  = 5'h00;
      for (i = 4; i >= 0; i = i - 1) begin
        k    = st[10] ^ st[8];
        o[i] = d[i] ^ k;
        st   = {st[9:0], k};
      end
      scr5 = {st, o};
    end
  endfunction

  // MLT-3 transmit: a one moves the level around 0,+,0,-.
  // State is {last nonzero was positive, level}; returns {state, levels}.
  function [12:0] mlt_tx;
    input [2:0] s;
    input [4:0] b;
    reg         dir;
    reg   [1:0] lv;
    reg   [9:0] o;
    integer     i;
    begin
      dir = s[2];
      lv  = s[1:0];
      o   = 10'h000;
      for (i = 4; i >= 0; i = i - 1) begin
        if (b[i]) begin
          if (lv == `PCS_LVL_ZERO) begin
            lv  = dir ? `PCS_LVL_NEG : `PCS_LVL_POS;
            dir = ~dir;
          end else begin
            lv = `PCS_LVL_ZERO;
          end
        end
        o[2*i +: 2] = lv;
      end
      mlt_tx = {dir, lv, o};
    end
  endfunction

  // MLT-3 receive: a one wherever the level changes
  function [4:0] mlt_rx;
    input [1:0] p;
    input [9:0] lv;
    reg   [1:0] prev;
    reg   [4:0] o;
    integer     i;
    begin
      prev = p;
      o    = 5'h00;
      for (i = 4; i >= 0; i = i - 1) begin
        o[i] = (lv[2*i +: 2] != prev);
        prev = lv[2*i +: 2];
      end
      mlt_rx = o;
    end
  endfunction

  // ------------------------
  // Transmit path
  // ------------------------
  reg [3:0]  tx_st_r;       // Transmit state
  reg [10:0] tx_scr_r;      // Scrambler state
  reg [2:0]  tx_mlt_r;      // MLT-3 direction and level
  reg [9:0]  tx_line_r;     // Line levels of the last symbol
  reg [3:0]  tx_st_nxt;     // Next transmit state
  reg [4:0]  tx_cg;         // Code group for this symbol time
  wire [15:0] tx_scr_res = scr5(tx_scr_r, tx_cg);
  wire [12:0] tx_mlt_res = mlt_tx(tx_mlt_r, tx_scr_res[4:0]);

  // Pick this symbol's code group; nibbles are taken as sampled
  always @* begin
    tx_st_nxt = tx_st_r;
    tx_cg     = `PCS_CG_IDLE;
    case (tx_st_r)
      TX_IDLE: begin
        if (txen_s2_r) begin
          tx_cg     = `PCS_CG_J;
          tx_st_nxt = TX_K;
        end else begin
          tx_cg     = `PCS_CG_IDLE;
        end
      end
      TX_K: begin
        // K follows J whatever the MAC does meanwhile
        tx_cg     = `PCS_CG_K;
        tx_st_nxt = TX_DATA;
      end
      TX_DATA: begin
        if (txen_s2_r) begin
          tx_cg     = enc4(txd_s2_r);
        end else begin
          tx_cg     = `PCS_CG_T;
          tx_st_nxt = TX_R;
        end
      end
      TX_R: begin
        tx_cg     = `PCS_CG_R;
        tx_st_nxt = TX_IDLE;
      end
      default: begin
        tx_st_nxt = TX_IDLE;
      end
    endcase
  end

  // One code group per line clock: scramble then MLT-3
  always @(posedge clk_sys_in) begin
    if (rst_in) begin
      tx_st_r   <= TX_IDLE;
      tx_scr_r  <= SCR_SEED;
      tx_mlt_r  <= {1'b0, `PCS_LVL_ZERO};
      tx_line_r <= 10'h000;
    end else if (line_rise) begin
      tx_st_r   <= tx_st_nxt;
      tx_scr_r  <= tx_scr_res[15:5];
      tx_mlt_r  <= tx_mlt_res[12:10];
      tx_line_r <= tx_mlt_res[9:0];
    end
  end

  wire tx_busy = (tx_st_r != TX_IDLE);

  // ------------------------
  // Receive path: MLT-3 decode, descramble, code group decode
  // ------------------------
  reg [3:0]  rx_st_r;       // Receive state
  reg [10:0] rx_scr_r;      // Descrambler state
  reg [1:0]  rx_prev_r;     // Last received level
  reg [5:0]  dec_data_r;    // Pending {dv, er, nibble}
  reg        dec_vld_r;     // Pending entry waits for the buffer
  wire [4:0]  rx_bits = mlt_rx(rx_prev_r, rxl_s2_r);
  wire [15:0] rx_dsc  = scr5(rx_scr_r, rx_bits);
  wire [4:0]  rx_cg   = rx_dsc[4:0];
  wire [4:0]  rx_dec  = dec5(rx_cg);
  // Out of lock the descrambler retrains, assuming idle was sent
  wire rx_train = (rx_st_r == RX_IDLE) & (rx_cg != `PCS_CG_IDLE) &
                  (rx_cg != `PCS_CG_J);
  wire buf_in_ready;        // Buffer can take the pending entry

  // Receive state machine, one step per line clock
  always @(posedge clk_sys_in) begin
    if (rst_in) begin
      rx_st_r    <= RX_IDLE;
      rx_scr_r   <= 11'h000;
      rx_prev_r  <= `PCS_LVL_ZERO;
      dec_data_r <= 6'h00;
      dec_vld_r  <= 1'b0;
    end else begin
      // Entry leaves once the buffer takes it
      if (dec_vld_r & buf_in_ready) begin
        dec_vld_r <= 1'b0;
      end
      if (line_rise) begin
        rx_prev_r <= rxl_s2_r[1:0];
        rx_scr_r  <= rx_train ? {rx_scr_r[5:0], ~rx_bits}
                              : rx_dsc[15:5];
        case (rx_st_r)
          RX_IDLE: begin
            if (rx_cg == `PCS_CG_J) begin
              // J shows as a preamble nibble
              dec_data_r <= {2'h2, `PCS_PRE_NIB};
              dec_vld_r  <= 1'b1;
              rx_st_r    <= RX_K;
            end
          end
          RX_K: begin
            if (rx_cg == `PCS_CG_K) begin
              dec_data_r <= {2'h2, `PCS_PRE_NIB};
              rx_st_r    <= RX_DATA;
            end else begin
              // Lone J: flag it and drop back
              dec_data_r <= {2'h3, `PCS_PRE_NIB};
              rx_st_r    <= RX_IDLE;
            end
            dec_vld_r <= 1'b1;
          end
          RX_DATA: begin
            if (rx_cg == `PCS_CG_T) begin
              rx_st_r <= RX_R;
            end else if (rx_cg == `PCS_CG_IDLE) begin
              // Idle without T/R ends carrier with one error beat
              dec_data_r <= {2'h1, 4'h0};
              dec_vld_r  <= 1'b1;
              rx_st_r    <= RX_IDLE;
            end else if (rx_dec[4]) begin
              dec_data_r <= {2'h2, rx_dec[3:0]};
              dec_vld_r  <= 1'b1;
            end else begin
              dec_data_r <= {2'h3, `PCS_PRE_NIB};
              dec_vld_r  <= 1'b1;
            end
          end
          RX_R: begin
            // R ends the stream; anything else also ends it, flagged
            if (rx_cg != `PCS_CG_R) begin
              dec_data_r <= {2'h1, 4'h0};
              dec_vld_r  <= 1'b1;
            end
            rx_st_r <= RX_IDLE;
          end
          default: begin
            rx_st_r <= RX_IDLE;
          end
        endcase
      end
    end
  end

  wire rx_carrier = (rx_st_r != RX_IDLE);

  // ------------------------
  // Receive buffer between decoder and MII output
  // ------------------------
  wire [5:0] buf_out_data;  // Oldest {dv, er, nibble}
  wire       buf_out_valid; // Buffer holds an entry

  // Absorbs the phase between decode and the next MII clock; a stall
  // holds the decoder's pending entry rather than dropping it
  pcs_buf2 #(
    .W (6)
  ) u_rx_buf (
    .clk_sys_in    (clk_sys_in),
    .rst_in        (rst_in),
    .in_data_in    (dec_data_r),
    .in_valid_in   (dec_vld_r),
    .in_ready_out  (buf_in_ready),
    .out_data_out  (buf_out_data),
    .out_valid_out (buf_out_valid),
    .out_ready_in  (line_rise)
  );

  // ------------------------
  // MII outputs, all registered
  // ------------------------
  reg       mii_clk_r;      // Shared transmit and receive clock
  reg [3:0] rxd_r;          // Receive nibble
  reg       rx_dv_r;        // Receive data valid
  reg       rx_er_r;        // Receive error
  reg       crs_r;          // Carrier sense
  reg       col_r;          // Collision

  // Both MII clocks follow the line symbol clock, so nibble and code
  // group rates match; 25 MHz when the line runs at 125 Mbaud
  always @(posedge clk_sys_in) begin
    if (rst_in) begin
      mii_clk_r <= 1'b0;
      rxd_r     <= 4'h0;
      rx_dv_r   <= 1'b0;
      rx_er_r   <= 1'b0;
      crs_r     <= 1'b0;
      col_r     <= 1'b0;
    end else begin
      mii_clk_r <= lclk_s2_r;
      if (line_rise) begin
        if (buf_out_valid) begin
          rx_dv_r <= buf_out_data[5];
          rx_er_r <= buf_out_data[4];
          rxd_r   <= buf_out_data[3:0];
        end else begin
          rx_dv_r <= 1'b0;
          rx_er_r <= 1'b0;
          rxd_r   <= 4'h0;
        end
      end
      // Transmit adds to carrier only in half duplex
      crs_r <= rx_carrier | (~fdx_s2_r & tx_busy);
      // Follows the overlap cycle by cycle, so it lasts as long
      col_r <= ~fdx_s2_r & tx_busy & rx_carrier;
    end
  end

  assign tx_clk_out  = mii_clk_r;
  assign rx_clk_out  = mii_clk_r;
  assign rxd_out     = rxd_r;
  assign rx_dv_out   = rx_dv_r;
  assign rx_er_out   = rx_er_r;
  assign crs_out     = crs_r;
  assign col_out     = col_r;
  assign tx_line_out = tx_line_r;

endmodule // fast_ethernet_pcs_4b5b_codec

// ==== pcs_codec_regs.vh ====
// Constants for the 100 Mbps 4B/5B coding sublayer: code groups,
// line levels and reset values.
// Assumes it is included by bare name from each design file.
`ifndef PCS_CODEC_REGS_VH
`define PCS_CODEC_REGS_VH

// ------------------------
// Data code groups, nibble 0 through F
// ------------------------
`define PCS_CG_D0    5'h1e
`define PCS_CG_D1    5'h09
`define PCS_CG_D2    5'h14
`define PCS_CG_D3    5'h15
`define PCS_CG_D4    5'h0a
`define PCS_CG_D5    5'h0b
`define PCS_CG_D6    5'h0e
`define PCS_CG_D7    5'h0f
`define PCS_CG_D8    5'h12
`define PCS_CG_D9    5'h13
`define PCS_CG_DA    5'h16
`define PCS_CG_DB    5'h17
`define PCS_CG_DC    5'h1a
`define PCS_CG_DD    5'h1b
`define PCS_CG_DE    5'h1c
`define PCS_CG_DF    5'h1d

// ------------------------
// Control code groups
// ------------------------
`define PCS_CG_IDLE  5'h1f
`define PCS_CG_J     5'h18
`define PCS_CG_K     5'h11
`define PCS_CG_T     5'h0d
`define PCS_CG_R     5'h07

// Nibble shown for the start delimiter and for bad code groups
`define PCS_PRE_NIB  4'h5

// ------------------------
// MLT-3 level codes, two bits per line bit
// ------------------------
`define PCS_LVL_ZERO 2'h0
`define PCS_LVL_POS  2'h1
`define PCS_LVL_NEG  2'h3

// ------------------------
// Reset values
// ------------------------
`define PCS_SCR_SEED 11'h7ff

`endif

// ==== pcs_buf2.v ====
// Two-entry buffer with valid and ready on both sides.
// Assumes one clock, synchronous active-high reset.
`timescale 1ns/1ns
`include "pcs_codec_regs.vh"

module pcs_buf2 #(
  parameter W = 6
) (
  // Clock and reset
  input  wire         clk_sys_in,
  input  wire         rst_in,
  // Fill side
  input  wire [W-1:0] in_data_in,
  input  wire         in_valid_in,
  output wire         in_ready_out,
  // Drain side
  output wire [W-1:0] out_data_out,
  output wire         out_valid_out,
  input  wire         out_ready_in
);

  reg [W-1:0] mem_r [0:1];  // Storage entries
  reg         wr_ptr_r;     // Next entry to write
  reg         rd_ptr_r;     // Next entry to read
  reg [1:0]   count_r;      // Entries held

  wire push = in_valid_in & in_ready_out;
  wire pop  = out_valid_out & out_ready_in;

  // Full and empty straight from the count, no look-ahead
  assign in_ready_out  = (count_r != 2'h2);
  assign out_valid_out = (count_r != 2'h0);
  assign out_data_out  = mem_r[rd_ptr_r];

  // ------------------------
  // Pointer and count update
  // ------------------------
  always @(posedge clk_sys_in) begin
    if (rst_in) begin
      wr_ptr_r <= 1'b0;
      rd_ptr_r <= 1'b0;
      count_r  <= 2'h0;
    end else begin
      if (push) begin
        mem_r[wr_ptr_r] <= in_data_in;
        wr_ptr_r        <= ~wr_ptr_r;
      end
      if (pop) begin
        rd_ptr_r <= ~rd_ptr_r;
      end
      // Simultaneous push and pop leave the count alone
      if (push & ~pop) begin
        count_r <= count_r + 2'h1;
      end else if (pop & ~push) begin
        count_r <= count_r - 2'h1;
      end
    end
  end

endmodule // pcs_buf2

// ==== pcs_codec_checker.sv ====
// Port checker for the 4B/5B coding sublayer.
// Assumes one system clock and a synchronous active-high reset.
`timescale 1ns/1ns
module pcs_codec_checker (
  // Clock and reset
  input wire       clk_sys_in,
  input wire       rst_in,
  // Transmit side
  input wire       line_clk_in,
  input wire [9:0] tx_line_out,
  input wire       tx_clk_out,
  // Receive side
  input wire       rx_clk_out,
  input wire [3:0] rxd_out,
  input wire       rx_dv_out,
  input wire       rx_er_out,
  input wire       crs_out,
  input wire       col_out,
  input wire       full_duplex_in
);
  // ------------------------------
  // Properties
  // ------------------------------
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (rst_in);
  // Reset silences every output
  reset_quiet_a: assert property (disable iff (1'b0) rst_in |=> tx_line_out == 10'h000
    && rxd_out == 4'h0 && !rx_dv_out && !rx_er_out && !crs_out && !col_out)
    else $error("outputs busy after reset");
  // MII clocks lag the line clock by three flops
  clk_follow_a: assert property (!$past(rst_in) && !$past(rst_in, 2)
    && !$past(rst_in, 3) |-> tx_clk_out == $past(line_clk_in, 3) && rx_clk_out == tx_clk_out)
    else $error("MII clock off the line clock");
  // Line symbol and receive nibble move only at a clock rise
  tx_hold_a: assert property (!$rose(tx_clk_out) |-> $stable(tx_line_out))
    else $error("line symbol moved mid symbol");
  rx_hold_a: assert property (!$rose(rx_clk_out) |-> $stable({rxd_out, rx_dv_out, rx_er_out}))
    else $error("receive nibble moved mid clock");
  // A bad code group shows the preamble nibble
  err_nibble_a: assert property (rx_er_out && rx_dv_out |-> rxd_out == 4'h5)
    else $error("bad symbol nibble wrong");
  // Frame opens with a clean preamble nibble
  dv_start_a: assert property ($rose(rx_dv_out) |-> rxd_out == 4'h5 && !rx_er_out)
    else $error("frame start nibble wrong");
  // No collision in full duplex
  col_fdx_a: assert property (full_duplex_in [*5] |-> !col_out)
    else $error("collision in full duplex");
  // Collision only while carrier is up
  col_crs_a: assert property (col_out |-> crs_out || $past(crs_out))
    else $error("collision without carrier");
endmodule // pcs_codec_checker

bind fast_ethernet_pcs_4b5b_codec pcs_codec_checker u_chk (
  .clk_sys_in(clk_sys_in), .rst_in(rst_in), .line_clk_in(line_clk_in),
  .tx_line_out(tx_line_out), .tx_clk_out(tx_clk_out), .rx_clk_out(rx_clk_out),
  .rxd_out(rxd_out), .rx_dv_out(rx_dv_out), .rx_er_out(rx_er_out),
  .crs_out(crs_out), .col_out(col_out), .full_duplex_in(full_duplex_in));

// ==== mac_tx_model.sv ====
// MAC stand-in driving the MII transmit side.
// Assumes the coding sublayer supplies the transmit clock.
`timescale 1ns/1ns
module mac_tx_model (
  // Clock and reset
  input  wire         clk_sys_in,
  input  wire         rst_in,
  // Frame request
  input  wire [127:0] nibs_in,
  input  wire [5:0]   len_in,
  input  wire         go_in,
  output reg          busy_out,
  // MII transmit
  input  wire         tx_clk_in,
  output reg  [3:0]   txd_out,
  output reg          tx_en_out
);
  reg       clk_q_r;  // Last transmit clock sample
  reg [5:0] idx_r;    // Next nibble to send
  // Change lines just after each clock rise, as a real MAC does
  always @(posedge clk_sys_in) begin
    clk_q_r <= tx_clk_in;
    if (rst_in) begin
      busy_out  <= 1'b0;
      tx_en_out <= 1'b0;
      txd_out   <= 4'h0;
      idx_r     <= 6'h0;
    end else begin
      if (tx_clk_in && !clk_q_r) begin
        if (busy_out && idx_r < len_in) begin
          // Enable rises with the first preamble nibble
          tx_en_out <= 1'b1;
          txd_out   <= nibs_in[idx_r*4 +: 4];
          idx_r     <= idx_r + 6'h1;
        end else begin
          // Idle data toggles so stale nibbles stand out
          tx_en_out <= 1'b0;
          txd_out   <= ~txd_out;
          busy_out  <= 1'b0;
        end
      end
      // A new request is ignored while the old one runs, its last cycle included
      if (go_in && !busy_out) begin
        busy_out <= 1'b1;
        idx_r    <= 6'h0;
      end
    end
  end
endmodule // mac_tx_model

// ==== tb.sv ====
// Self-checking bench for the 4B/5B coding sublayer.
// Assumes the bench is the line side; the MAC model feeds the MII.
`timescale 1ns/1ns
`define CHK(n, e, g) begin cmp_count++; if ((e) !== (g)) begin error_cnt++; \
  $display("wrong value %s exp %h got %h", n, e, g); end end
module tb;
  // Data code groups 0..F and invalid receive codes
  localparam [79:0] ENC = {5'h1d, 5'h1c, 5'h1b, 5'h1a, 5'h17, 5'h16, 5'h13, 5'h12,
                           5'h0f, 5'h0e, 5'h0b, 5'h0a, 5'h15, 5'h14, 5'h09, 5'h1e};
  localparam [49:0] BAD = {5'h19, 5'h10, 5'h0c, 5'h08, 5'h06,
                           5'h05, 5'h03, 5'h02, 5'h01, 5'h00};
  reg          clk_sys_in = 1'b0;
  reg          rst_in = 1'b1;
  reg          line_clk_in = 1'b0;
  reg  [9:0]   rx_line_in = 10'h000;
  reg          full_duplex_in = 1'b0;
  wire [9:0]   tx_line_out;
  wire [3:0]   rxd_out, txd;
  wire         tx_clk_out, rx_clk_out, rx_dv_out, rx_er_out, crs_out, col_out, tx_en, busy;
  reg  [127:0] nibs = 128'h0;
  reg  [5:0]   len = 6'h0;
  reg          go = 1'b0;
  integer      error_cnt = 0;
  integer      cmp_count = 0;
  integer      seed = 44;
  integer      trn = 0;       // Idle symbols used to train
  reg  [4:0]   txq[$];        // Expected line code groups
  reg  [4:0]   gotq[$];       // Code groups seen on the line
  reg  [10:0]  rxq[$];        // {expected outputs, code group}
  reg  [10:0]  ds_r = 11'h0;  // Line-side descrambler
  reg  [10:0]  sc_r = 11'h2a5;// Line-side scrambler, any seed
  reg  [1:0]   mi_r = 2'h0;   // MLT-3 step
  reg  [1:0]   pl_r = 2'h0;   // Last transmit level
  reg  [5:0]   p1_r = 6'h0;   // Outputs due next symbol
  reg  [5:0]   p2_r = 6'h0;   // Outputs due now
  always #5 clk_sys_in = ~clk_sys_in;
  // Line clock runs free, idle fills between frames
  initial #3 forever #80 line_clk_in = ~line_clk_in;
  fast_ethernet_pcs_4b5b_codec dut (
    .clk_sys_in(clk_sys_in), .rst_in(rst_in), .line_clk_in(line_clk_in),
    .rx_line_in(rx_line_in), .tx_line_out(tx_line_out), .tx_clk_out(tx_clk_out),
    .txd_in(txd), .tx_en_in(tx_en), .rx_clk_out(rx_clk_out), .rxd_out(rxd_out),
    .rx_dv_out(rx_dv_out), .rx_er_out(rx_er_out), .crs_out(crs_out),
    .col_out(col_out), .full_duplex_in(full_duplex_in));
  mac_tx_model u_mac (
    .clk_sys_in(clk_sys_in), .rst_in(rst_in), .nibs_in(nibs), .len_in(len),
    .go_in(go), .busy_out(busy), .tx_clk_in(tx_clk_out), .txd_out(txd),
    .tx_en_out(tx_en));
  function [4:0] enc(input [3:0] n);
    enc = ENC[n*5 +: 5];
  endfunction
  // ------------------------------
  // Line side, once per symbol
  // ------------------------------
  always @(negedge line_clk_in) begin : line_side
    reg [4:0]  cg;
    reg [10:0] sym;
    reg [9:0]  lv;
    reg        b;
    reg        k;
    integer    i;
    @(posedge clk_sys_in);
    if (!rst_in) begin
      // Undo MLT-3, then descramble; first symbols train on idle
      for (i = 4; i >= 0; i--) begin
        b = (tx_line_out[2*i +: 2] != pl_r);
        pl_r = tx_line_out[2*i +: 2];
        k = (trn < 4) ? ~b : ds_r[10] ^ ds_r[8];
        cg[i] = b ^ k;
        ds_r = {ds_r[9:0], k};
      end
      if (trn < 4) trn++;
      else if (cg != 5'h1f) gotq.push_back(cg);
      // Receive outputs lag the driven symbol by two symbols
      `CHK("rx_dv", p2_r[4], rx_dv_out)
      `CHK("rx_er", p2_r[5], rx_er_out)
      if (p2_r[5:4] != 2'b00) `CHK("rxd", p2_r[3:0], rxd_out)
      p2_r = p1_r;
      sym = (rxq.size() > 0) ? rxq.pop_front() : {6'h00, 5'h1f};
      p1_r = sym[10:5];
      for (i = 4; i >= 0; i--) begin
        k = sc_r[10] ^ sc_r[8];
        sc_r = {sc_r[9:0], k};
        if (sym[i] ^ k) mi_r = mi_r + 2'h1;
        lv[2*i +: 2] = mi_r[0] ? (mi_r[1] ? 2'h3 : 2'h1) : 2'h0;
      end
      rx_line_in <= lv;
    end
  end
  // Start one MAC frame and queue the code groups it must become
  task tx_start(input integer n, input integer rnd);
    integer i, r;
    reg [127:0] w;
    begin
      w = 128'h0;
      txq.push_back(5'h18);
      txq.push_back(5'h11);
      for (i = 0; i < n; i++) begin
        r = rnd ? $random(seed) : i;
        w[i*4 +: 4] = r[3:0];
        if (i > 1) txq.push_back(enc(r[3:0]));
      end
      txq.push_back(5'h0d);
      txq.push_back(5'h07);
      @(posedge clk_sys_in);
      nibs <= w;
      len  <= n[5:0];
      go   <= 1'b1;
      @(posedge clk_sys_in);
      go   <= 1'b0;
    end
  endtask
  task tx_end;
    integer i;
    begin
      repeat (2) @(posedge clk_sys_in);
      for (i = 0; i < 9000 && busy; i++) @(posedge clk_sys_in);
      repeat (5) @(negedge line_clk_in);
      `CHK("tx count", txq.size(), gotq.size())
      for (i = 0; i < txq.size() && i < gotq.size(); i++)
        `CHK("tx code", txq[i], gotq[i])
      txq.delete();
      gotq.delete();
      $display("test tx frame done");
    end
  endtask
  // Queue a received frame; bad code at nibble 1, or idle cut short
  task rx_frame(input integer n, input [4:0] bad, input integer clean);
    integer i, r;
    begin
      rxq.push_back({6'h15, 5'h18});
      rxq.push_back({6'h15, 5'h11});
      for (i = 0; i < n; i++) begin
        r = $random(seed);
        if (i == 1 && bad != 5'h1f) rxq.push_back({6'h35, bad});
        else rxq.push_back({2'b01, r[3:0], enc(r[3:0])});
      end
      if (clean) begin
        rxq.push_back({6'h00, 5'h0d});
        rxq.push_back({6'h00, 5'h07});
      end else rxq.push_back({6'h20, 5'h1f});
      for (i = 0; i < 4; i++) rxq.push_back({6'h00, 5'h1f});
    end
  endtask
  task rx_wait;
    integer i;
    begin
      for (i = 0; i < 9000 && rxq.size() > 0; i++) @(posedge clk_sys_in);
      repeat (3) @(negedge line_clk_in);
      $display("test rx frame done");
    end
  endtask
  task final_report;
    begin
      $display("compares %0d mismatches %0d", cmp_count, error_cnt);
      if (error_cnt == 0 && cmp_count > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
    end
  endtask
  // Watchdog past the expected run length
  initial begin
    #600000;
    error_cnt++;
    final_report;
  end
  initial begin : main
    integer i, r;
    repeat (12) @(posedge clk_sys_in);
    rst_in <= 1'b0;
    repeat (8) @(negedge line_clk_in);
    // Every nibble value, short frames, then random frames
    tx_start(18, 0);
    tx_end;
    for (i = 1; i < 8; i++) begin
      r = $random(seed);
      tx_start(i < 4 ? i : 1 + r[4:0] % 24, 1);
      tx_end;
    end
    // Ten invalid codes once each, then a frame cut short by idle
    for (i = 0; i < 10; i++) begin
      rx_frame(4, BAD[i*5 +: 5], 1);
      rx_wait;
    end
    rx_frame(6, 5'h1f, 0);
    rx_wait;
    // Both directions at once, half then full duplex
    for (i = 0; i < 2; i++) begin
      @(posedge clk_sys_in);
      full_duplex_in <= (i == 1);
      tx_start(24, 1);
      rx_frame(16, 5'h1f, 1);
      repeat (10) @(negedge line_clk_in);
      @(posedge clk_sys_in);
      `CHK("col", (i == 0), col_out)
      `CHK("crs", 1'b1, crs_out)
      rx_wait;
      tx_end;
    end
    final_report;
  end
endmodule // tb
